// ===== pkg/ids_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

// File register port between the sequencer and the register memory.
interface ids_mem_if #(
    parameter int AW = 7,
    parameter int DW = 8
);
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;

    modport exec (output rd_addr, input rd_data,
                  output wr_en, output wr_addr, output wr_data);
    modport mem  (input rd_addr, output rd_data,
                  input wr_en, input wr_addr, input wr_data);
endinterface

`default_nettype wire

// ===== pkg/ids_pkg.sv
`default_nettype none

// Shared widths, field positions, encodings and reset values.
package ids_pkg;
    localparam int INSTR_W  = 14;
    localparam int ADDR_W   = 7;
    localparam int DATA_W   = 8;
    localparam int PC_W     = 13;
    localparam int BR_K_W   = 11;
    localparam int PAGE_W   = 8;
    localparam int OP_LSB   = 11;
    localparam int DIR_BIT  = 7;
    localparam int PAGE_LO  = 3;
    localparam int PAGE_HI  = 4;

    localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST     = 13'h0000;
    localparam logic              ZERO_RST   = 1'h0;
    localparam logic [DATA_W-1:0] ONE        = 8'h01;
    localparam logic [DATA_W-1:0] ZERO_VAL   = 8'h00;

    // Operation field of the instruction word, bits 13 down to 11.
    typedef enum logic [2:0] {
        OP_NOP      = 3'h0,
        OP_DEC_SKIP = 3'h1,
        OP_INC_SKIP = 3'h2,
        OP_INC      = 3'h3,
        OP_BRANCH   = 3'h4,
        OP_OR_LIT   = 3'h5
    } ids_op_e;

    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_EXEC = 3'h2,
        ST_SLOT = 3'h4
    } ids_state_e;
endpackage

`default_nettype wire

// ===== tb/ids_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench: a reference model follows every instruction.
module ids_exec_tb;
    import ids_pkg::*;
    logic               ref_clk;
    logic               rst;
    logic               instr_valid;
    logic [INSTR_W-1:0] instr_word;
    logic [PAGE_W-1:0]  pc_page_latch;
    logic               acc_load;
    logic [DATA_W-1:0]  acc_load_data;
    logic               ext_wr_en;
    logic [ADDR_W-1:0]  ext_wr_addr;
    logic [DATA_W-1:0]  ext_wr_data;
    logic               instr_ready;
    logic [DATA_W-1:0]  acc;
    logic               zero_flag;
    logic [PC_W-1:0]    pc;
    logic               pc_load;
    logic               nop_slot;
    logic               instr_done;
    logic [DATA_W-1:0]  result;
    int                 n_fail;
    int                 tests_run;
    logic [DATA_W-1:0]  m_mem [128];
    logic [DATA_W-1:0]  m_acc;
    logic               m_z;

    ids_exec dut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .pc_page_latch(pc_page_latch),
        .acc_load(acc_load), .acc_load_data(acc_load_data),
        .ext_wr_en(ext_wr_en), .ext_wr_addr(ext_wr_addr),
        .ext_wr_data(ext_wr_data), .instr_ready(instr_ready), .acc(acc),
        .zero_flag(zero_flag), .pc(pc), .pc_load(pc_load),
        .nop_slot(nop_slot), .instr_done(instr_done), .result(result));

    // Clock of 20 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Counts a comparison and reports a mismatch.
    task automatic chk(input string what, input logic [12:0] exp,
                       input logic [12:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Moves one cycle on, landing just after the rising edge.
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    // Prints the totals and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Writes one file register through the preload port.
    task automatic preload(input int a, input logic [7:0] d);
        ext_wr_en = 1'b1;
        ext_wr_addr = a[6:0];
        ext_wr_data = d;
        tick();
        ext_wr_en = 1'b0;
        m_mem[a] = d;
    endtask

    // Loads the accumulator while the core is idle.
    task automatic load_acc(input logic [7:0] d);
        acc_load = 1'b1;
        acc_load_data = d;
        tick();
        acc_load = 1'b0;
        m_acc = d;
        chk("acc load", {5'h00, d}, {5'h00, acc});
    endtask

    // Issues one instruction and checks the outputs at their exact cycle: pc only for a branch, result only for other ops.
    task automatic run(input logic [2:0] op, input logic [10:0] k);
        logic [7:0] r;
        logic       skip;
        int         n;
        r = 8'h00;
        skip = 1'b0;
        n = 0;
        while (instr_ready !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        pc_page_latch = 8'($urandom);
        instr_word = {op, k};
        instr_valid = 1'b1;
        tick();
        instr_valid = 1'b0;
        chk("ready in exec", 13'h0000, {12'h000, instr_ready});
        case (op)
            3'h1: r = m_mem[k[6:0]] - ONE;
            3'h2, 3'h3: r = m_mem[k[6:0]] + ONE;
            3'h5: r = m_acc | k[7:0];
            default: r = m_acc;
        endcase
        if (op == 3'h1 || op == 3'h2) skip = (r == 8'h00);
        if (op == 3'h3 || op == 3'h5) m_z = (r == 8'h00);
        if (op == 3'h4) skip = 1'b1;
        if (op == 3'h5 || ((op inside {3'h1, 3'h2, 3'h3}) && !k[DIR_BIT]))
            m_acc = r;
        else if (op inside {3'h1, 3'h2, 3'h3})
            m_mem[k[6:0]] = r;
        tick();
        chk("done", 13'h0001, {12'h000, instr_done});
        chk("acc", {5'h00, m_acc}, {5'h00, acc});
        chk("zero", {12'h000, m_z}, {12'h000, zero_flag});
        chk("pc load", {12'h000, op == 3'h4}, {12'h000, pc_load});
        if (op == 3'h4) begin
            chk("pc", {pc_page_latch[4:3], k}, pc);
        end else begin
            chk("result", {5'h00, r}, {5'h00, result});
        end
        chk("ready", {12'h000, !skip}, {12'h000, instr_ready});
        chk("slot", {12'h000, skip}, {12'h000, nop_slot});
        tick();
        chk("done pulse", 13'h0000, {12'h000, instr_done});
        chk("slot pulse", 13'h0000, {12'h000, nop_slot});
        chk("ready after", 13'h0001, {12'h000, instr_ready});
    endtask

    // Gives up on a hung run.
    initial begin
        #(20 * 5000);
        n_fail++;
        results();
    end

    // Main sequence: reset, directed corners, then random instructions.
    initial begin
        rst = 1'b1;
        instr_valid = 1'b0;
        instr_word = '0;
        pc_page_latch = '0;
        acc_load = 1'b0;
        acc_load_data = '0;
        ext_wr_en = 1'b0;
        ext_wr_addr = '0;
        ext_wr_data = '0;
        n_fail = 0;
        tests_run = 0;
        m_acc = ACC_RST;
        m_z = ZERO_RST;
        void'($urandom(2484));
        repeat (4) tick();
        chk("reset acc", 13'h0000, {5'h00, acc});
        chk("reset pc", PC_RST, pc);
        rst = 1'b0;
        for (int i = 0; i < 128; i++) preload(i, 8'($urandom));
        $display("test reset and preload done");
        preload(5, 8'h01);
        run(3'h1, 11'h085);
        run(3'h1, 11'h005);
        preload(9, 8'hFF);
        run(3'h2, 11'h009);
        run(3'h3, 11'h089);
        run(3'h3, 11'h009);
        $display("test skip and wrap done");
        load_acc(8'h00);
        run(3'h5, 11'h000);
        run(3'h5, 11'h080);
        run(3'h4, 11'h7FF);
        run(3'h4, 11'h000);
        run(3'h0, 11'h7FF);
        run(3'h6, 11'h0FF);
        $display("test literal and branch done");
        for (int i = 0; i < 60; i++) begin
            if (i % 7 == 0) load_acc(8'($urandom));
            run(3'(1 + $urandom % 5), 11'($urandom));
        end
        $display("test random mix done");
        results();
    end
endmodule // ids_exec_tb

`default_nettype wire

// ===== verilog/ids_exec.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Decrement-skip subtracts one from file register; direction picks acc or file.
// - Decrement-skip: nonzero runs next; zero inserts a no-op slot; flags kept.
// - Increment-skip adds one, stores per direction, zero inserts no-op slot.
// - Branch loads its eleven-bit operand into program counter bits 10..0.
// - Branch fills program counter bits 12..11 from page latch bits 4..3.
// - Branch always takes two instruction cycles and keeps all flags.
// - Literal OR merges eight-bit operand into acc and updates zero flag.
// - Plain increment adds one, stores per direction, updates zero flag.
module ids_exec #(
    parameter int FILE_DEPTH = 128
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          instr_valid,
    input  wire logic [ids_pkg::INSTR_W-1:0]   instr_word,
    input  wire logic [ids_pkg::PAGE_W-1:0]    pc_page_latch,
    input  wire logic                          acc_load,
    input  wire logic [ids_pkg::DATA_W-1:0]    acc_load_data,
    input  wire logic                          ext_wr_en,
    input  wire logic [ids_pkg::ADDR_W-1:0]    ext_wr_addr,
    input  wire logic [ids_pkg::DATA_W-1:0]    ext_wr_data,
    output logic                               instr_ready,
    output logic [ids_pkg::DATA_W-1:0]         acc,
    output logic                               zero_flag,
    output logic [ids_pkg::PC_W-1:0]           pc,
    output logic                               pc_load,
    output logic                               nop_slot,
    output logic                               instr_done,
    output logic [ids_pkg::DATA_W-1:0]         result
);
    import ids_pkg::*;

    ids_state_e                 state;
    ids_op_e                    op;
    logic                       dir;
    logic [ADDR_W-1:0]          faddr;
    logic [BR_K_W-1:0]          opnd;
    logic [DATA_W-1:0]          next_res;
    logic                       is_file_op;
    logic                       is_skip_op;
    logic                       accept;

    ids_mem_if #(.AW(ADDR_W), .DW(DATA_W)) mif ();

    ids_file_mem #(.DEPTH(FILE_DEPTH)) u_mem (
        .ref_clk (ref_clk),
        .mif     (mif)
    );

    assign accept     = instr_valid && instr_ready;
    assign is_file_op = (op == OP_DEC_SKIP) || (op == OP_INC_SKIP)
                        || (op == OP_INC);
    assign is_skip_op = (op == OP_DEC_SKIP) || (op == OP_INC_SKIP);

    // The operand read is issued as the instruction is taken.
    assign mif.rd_addr = instr_word[ADDR_W-1:0];

    // Result of the latched instruction, wrapping in eight bits.
    always_comb begin
        case (op)
            OP_DEC_SKIP: next_res = mif.rd_data - ONE;
            OP_INC_SKIP: next_res = mif.rd_data + ONE;
            OP_INC:      next_res = mif.rd_data + ONE;
            OP_OR_LIT:   next_res = acc | opnd[DATA_W-1:0];
            default:     next_res = acc;
        endcase
    end

    // File write-back when direction is set; external preload otherwise.
    always_comb begin
        if ((state == ST_EXEC) && is_file_op && dir) begin
            mif.wr_en   = 1'h1;
            mif.wr_addr = faddr;
            mif.wr_data = next_res;
        end else begin
            mif.wr_en   = ext_wr_en;
            mif.wr_addr = ext_wr_addr;
            mif.wr_data = ext_wr_data;
        end
    end

    // Sequencer: take, execute, then an optional no-op slot.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (op == OP_BRANCH) begin
                        state <= ST_SLOT;
                    end else if (is_skip_op && (next_res == ZERO_VAL)) begin
                        state <= ST_SLOT;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_SLOT: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Latch the fields of a taken instruction.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op    <= OP_NOP;
            dir   <= 1'h0;
            faddr <= '0;
            opnd  <= '0;
        end else if (accept) begin
            op    <= ids_op_e'(instr_word[INSTR_W-1:OP_LSB]);
            dir   <= instr_word[DIR_BIT];
            faddr <= instr_word[ADDR_W-1:0];
            opnd  <= instr_word[BR_K_W-1:0];
        end
    end

    // Handshake and cycle markers.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            instr_ready <= 1'h0;
            instr_done  <= 1'h0;
            nop_slot    <= 1'h0;
        end else begin
            instr_done  <= (state == ST_EXEC);
            nop_slot    <= (state == ST_EXEC) && (next_state_slot());
            instr_ready <= (state == ST_IDLE) ? !accept
                           : ((state == ST_SLOT)
                              || ((state == ST_EXEC) && !next_state_slot()));
        end
    end

    function automatic logic next_state_slot();
        return (op == OP_BRANCH)
               || (is_skip_op && (next_res == ZERO_VAL));
    endfunction

    // Accumulator: preload while idle, literal OR results, file-op results when direction is clear.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc <= ACC_RST;
        end else if (state == ST_EXEC) begin
            if (op == OP_OR_LIT) begin
                acc <= next_res;
            end else if (is_file_op && !dir) begin
                acc <= next_res;
            end
        end else if ((state == ST_IDLE) && acc_load) begin
            acc <= acc_load_data;
        end
    end

    // Zero flag: only the plain increment and literal OR touch it.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            zero_flag <= ZERO_RST;
        end else if ((state == ST_EXEC)
                     && ((op == OP_INC) || (op == OP_OR_LIT))) begin
            zero_flag <= (next_res == ZERO_VAL);
        end
    end

    // Program counter load on branch.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pc      <= PC_RST;
            pc_load <= 1'h0;
        end else begin
            pc_load <= (state == ST_EXEC) && (op == OP_BRANCH);
            if ((state == ST_EXEC) && (op == OP_BRANCH)) begin
                pc <= {pc_page_latch[PAGE_HI:PAGE_LO], opnd};
            end
        end
    end

    // Last computed result for observation.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            result <= ZERO_VAL;
        end else if ((state == ST_EXEC) && (op != OP_BRANCH)) begin
            result <= next_res;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_exec_skip_zero;
        (state == ST_EXEC) && is_skip_op && (next_res == ZERO_VAL);
    endsequence

    sequence s_slot_then_ready;
        nop_slot && !instr_ready ##1 instr_ready;
    endsequence

    a_dec_acc_dest: assert property (
        (state == ST_EXEC) && (op == OP_DEC_SKIP) && !dir
        |=> acc == DATA_W'($past(mif.rd_data) - ONE))
        else $error("decrement result not placed in acc");

    a_dec_skip_slot: assert property (
        s_exec_skip_zero |=> s_slot_then_ready)
        else $error("zero skip result did not insert a no-op slot");

    a_no_skip_run: assert property (
        (state == ST_EXEC) && is_skip_op && (next_res != ZERO_VAL)
        |=> !nop_slot && instr_ready)
        else $error("nonzero skip result stalled the next instruction");

    a_skip_flags_kept: assert property (
        (state == ST_EXEC) && is_skip_op |=> $stable(zero_flag))
        else $error("skip instruction changed the zero flag");

    a_branch_low_bits: assert property (
        (state == ST_EXEC) && (op == OP_BRANCH)
        |=> pc[BR_K_W-1:0] == $past(opnd) && pc_load)
        else $error("branch operand not loaded into low counter bits");

    a_branch_page_bits: assert property (
        (state == ST_EXEC) && (op == OP_BRANCH)
        |=> pc[PC_W-1:BR_K_W] == $past(pc_page_latch[PAGE_HI:PAGE_LO]))
        else $error("branch upper counter bits not from page latch");

    a_branch_two_cycles: assert property (
        (state == ST_EXEC) && (op == OP_BRANCH)
        |=> s_slot_then_ready and $stable(zero_flag) [*2])
        else $error("branch not two cycles or flags changed");

    a_or_literal: assert property (
        (state == ST_EXEC) && (op == OP_OR_LIT)
        |=> acc == ($past(acc) | $past(opnd[DATA_W-1:0]))
            && zero_flag == (acc == ZERO_VAL))
        else $error("literal OR result or zero flag wrong");

    a_inc_file_dest: assert property (
        (state == ST_EXEC) && (op == OP_INC) && dir
        |-> mif.wr_en && mif.wr_data == DATA_W'(mif.rd_data + ONE)
            ##1 $stable(acc) && zero_flag == (result == ZERO_VAL))
        else $error("increment file write-back or zero flag wrong");

    a_inc_wrap: assert property (
        (state == ST_EXEC) && (op == OP_INC) && (mif.rd_data == 8'hFF)
        |=> zero_flag && result == ZERO_VAL)
        else $error("increment did not wrap to zero");
endmodule // ids_exec

`default_nettype wire

// ===== verilog/ids_file_mem.sv
`timescale 1ns/1ps
`default_nettype none

// File register array; read data come out of a register one cycle later.
module ids_file_mem #(
    parameter int DEPTH = 128
) (
    input  wire logic ref_clk,
    ids_mem_if.mem    mif
);
    logic [7:0] store [DEPTH];

    // A read of the address being written returns the old contents.
    always_ff @(posedge ref_clk) begin
        if (mif.wr_en) begin
            store[mif.wr_addr] <= mif.wr_data;
        end
        mif.rd_data <= store[mif.rd_addr];
    end
endmodule // ids_file_mem

`default_nettype wire
